/* File: design/btwd_defines.svh */
`ifndef BTWD_DEFINES_SVH
`define BTWD_DEFINES_SVH

`define BTWD_ADDR_CONTROL   8'hd3
`define BTWD_ADDR_COUNT     8'hfd
`define BTWD_CONTROL_RESET  8'h00
`define BTWD_KEY_MSB        7
`define BTWD_KEY_LSB        4
`define BTWD_KEY_DISABLE    4'ha
`define BTWD_SEL_MSB        3
`define BTWD_SEL_LSB        2
`define BTWD_CNT_CLR_BIT    1
`define BTWD_DIV_CLR_BIT    0
`define BTWD_SEL_4096       2'h0
`define BTWD_SEL_1024       2'h1
`define BTWD_SEL_128        2'h2
`define BTWD_TAP_4096       11
`define BTWD_TAP_1024       9
`define BTWD_TAP_128        6
`define BTWD_DIV_WIDTH      12
`define BTWD_ZERO_BYTE      8'h00
`define BTWD_COUNT_MAX      8'hff
`define BTWD_COUNT_STEP     8'h01

`endif

/* File: design/btwd_pkg.sv */
package btwd_pkg;

	typedef struct packed {
		logic [3:0] key;
		logic [1:0] sel;
		logic       cnt_clr;
		logic       div_clr;
	} btwd_control_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} btwd_reg_req_type;

endpackage : btwd_pkg

/* File: design/btwd_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "btwd_defines.svh"

module btwd_prescaler
	import btwd_pkg::*;
#(
	parameter int DIV_WIDTH = `BTWD_DIV_WIDTH
) (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       div_clear,
	input  wire logic [1:0] sel,
	output var  logic       tick
);
	initial begin
		if (DIV_WIDTH < `BTWD_TAP_4096 + 1)
			$error("btwd_prescaler: DIV_WIDTH too small for the slowest tap");
	end

	logic [DIV_WIDTH-1:0] div_count;
	logic [DIV_WIDTH-1:0] next_div_count;
	logic                 tap_bit;
	logic                 tap_prev;
	logic                 next_tap_prev;
	logic                 next_tick;

	always_comb begin
		next_div_count = div_count + 1'b1;
		if (div_clear)
			next_div_count = '0;
		case (sel)
			`BTWD_SEL_4096: tap_bit = div_count[`BTWD_TAP_4096];
			`BTWD_SEL_1024: tap_bit = div_count[`BTWD_TAP_1024];
			`BTWD_SEL_128:  tap_bit = div_count[`BTWD_TAP_128];
			default:        tap_bit = 1'b0;
		endcase
		next_tap_prev = div_clear ? 1'b0 : tap_bit;
		// Falling edge of the chosen tap: one pulse per full divide period
		next_tick = tap_prev & ~tap_bit & ~div_clear;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			div_count <= '0;
			tap_prev  <= 1'b0;
			tick      <= 1'b0;
		end else begin
			div_count <= next_div_count;
			tap_prev  <= next_tap_prev;
			tick      <= next_tick;
		end
	end

endmodule : btwd_prescaler

`default_nettype wire

/* File: design/btwd_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "btwd_defines.svh"

module btwd_ctrl
	import btwd_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	input  wire btwd_reg_req_type reg_req,
	output var  logic [7:0]       reg_rdata,
	output var  logic             reg_hit,
	output var  logic             divider_clear,
	output var  logic             watchdog_enabled,
	output var  logic             system_reset_req
);
	// Stored control fields
	btwd_control_type control;
	btwd_control_type next_control;

	// Basic timer count
	logic [7:0]       count;
	logic [7:0]       next_count;
	logic             count_wrap;

	// Read port
	logic [7:0]       next_rdata;
	logic             next_hit;
	logic             rd_control;
	logic             rd_count;

	// Pulse outputs
	logic             next_div_clear;
	logic             next_reset_req;

	// Write decode and prescaler tick
	logic             tick;
	logic             wr_control;
	logic             cnt_clear;
	logic             div_clear_now;
	logic             any_clear;

	// Writes to the count address fall through: the count is read-only
	assign wr_control    = reg_req.wr && (reg_req.addr == `BTWD_ADDR_CONTROL);
	assign rd_control    = reg_req.rd && (reg_req.addr == `BTWD_ADDR_CONTROL);
	assign rd_count      = reg_req.rd && (reg_req.addr == `BTWD_ADDR_COUNT);
	assign cnt_clear     = wr_control && reg_req.wdata[`BTWD_CNT_CLR_BIT];
	assign div_clear_now = wr_control && reg_req.wdata[`BTWD_DIV_CLR_BIT];

	// A divider restart also restarts the count, so both clears act alike on it
	assign any_clear     = cnt_clear || div_clear_now;

	// Last count value before wrap, with a tick due
	assign count_wrap    = tick && (count == `BTWD_COUNT_MAX);

	btwd_prescaler #(
		.DIV_WIDTH (`BTWD_DIV_WIDTH)
	) u_prescaler (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.div_clear (div_clear_now),
		.sel       (control.sel),
		.tick      (tick)
	);

	// Control group
	always_comb begin
		next_control = control;
		// Clear bits never store: they read back as zero after the write
		next_control.cnt_clr = 1'b0;
		next_control.div_clr = 1'b0;
		if (wr_control) begin
			next_control.key = reg_req.wdata[`BTWD_KEY_MSB:`BTWD_KEY_LSB];
			next_control.sel = reg_req.wdata[`BTWD_SEL_MSB:`BTWD_SEL_LSB];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			control <= `BTWD_CONTROL_RESET;
		end else begin
			control <= next_control;
		end
	end

	// Count group: a clear in the same cycle as a tick wins
	always_comb begin
		next_count = count;
		if (any_clear) begin
			next_count = `BTWD_ZERO_BYTE;
		end else if (tick) begin
			next_count = count + `BTWD_COUNT_STEP;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			count <= `BTWD_ZERO_BYTE;
		end else begin
			count <= next_count;
		end
	end

	// Only the exact key disables the watchdog
	assign watchdog_enabled = (control.key != `BTWD_KEY_DISABLE);

	// Watchdog group: a wrap while armed asks for a system reset
	always_comb begin
		next_reset_req = 1'b0;
		if (!any_clear && count_wrap && watchdog_enabled) begin
			next_reset_req = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			system_reset_req <= 1'b0;
		end else begin
			system_reset_req <= next_reset_req;
		end
	end

	// Divider clear group: tells the neighbouring timer its divider restarted
	always_comb begin
		next_div_clear = div_clear_now;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			divider_clear <= 1'b0;
		end else begin
			divider_clear <= next_div_clear;
		end
	end

	// Read group: unmapped reads return zero with no hit
	always_comb begin
		next_hit   = 1'b0;
		next_rdata = `BTWD_ZERO_BYTE;
		if (rd_control) begin
			next_hit   = 1'b1;
			next_rdata = control;
		end else if (rd_count) begin
			next_hit   = 1'b1;
			next_rdata = count;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= `BTWD_ZERO_BYTE;
			reg_hit   <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			reg_hit   <= next_hit;
		end
	end

endmodule : btwd_ctrl

`default_nettype wire

/* File: sim/btwd_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module btwd_chk
	import btwd_pkg::*;
(
	input wire logic             clk_sys,
	input wire logic             resetn,
	input wire btwd_reg_req_type reg_req,
	input wire logic [7:0]       reg_rdata,
	input wire logic             reg_hit,
	input wire logic             divider_clear,
	input wire logic             watchdog_enabled,
	input wire logic             system_reset_req
);
	wire wc = reg_req.wr && reg_req.addr == 8'hd3;
	wire rc = reg_req.rd && reg_req.addr == 8'hd3;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_wr; wc; endsequence
	sequence s_rd; rc; endsequence
	chk_key_off: assert property (wc && reg_req.wdata[7:4] == 4'ha |=> !watchdog_enabled)
		else $error("key off");
	chk_key_on: assert property (wc && reg_req.wdata[7:4] != 4'ha |=> watchdog_enabled)
		else $error("key on");
	chk_reset_src: assert property (system_reset_req |-> $past(watchdog_enabled))
		else $error("reset source");
	chk_read_back: assert property (s_wr ##1 s_rd |=>
		reg_hit && reg_rdata == {$past(reg_req.wdata[7:2], 2), 2'h0}) else $error("read back");
	chk_div_pulse: assert property (wc && reg_req.wdata[0] |=> divider_clear)
		else $error("div pulse");
	chk_div_quiet: assert property (!(wc && reg_req.wdata[0]) |=> !divider_clear)
		else $error("div quiet");
	chk_map_miss: assert property (reg_req.rd && !rc && reg_req.addr != 8'hfd |=>
		!reg_hit && reg_rdata == 8'h00) else $error("unmapped");
	chk_ctl_low: assert property (s_rd |=> reg_rdata[1:0] == 2'h0) else $error("low bits");
endmodule : btwd_chk
bind btwd_ctrl btwd_chk u_chk (.*);
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import btwd_pkg::*;
;
	logic             clk_sys = 0;
	logic             resetn = 0;
	btwd_reg_req_type reg_req = '0;
	logic [7:0]       reg_rdata;
	logic             reg_hit, divider_clear, watchdog_enabled, system_reset_req;
	logic             rd_d = 0;
	logic [8:0]       exp_q[$];
	int               fails = 0, total_checks = 0, pulses = 0;
	always #5 clk_sys = ~clk_sys;
	btwd_ctrl uut (
		.clk_sys          (clk_sys),
		.resetn           (resetn),
		.reg_req          (reg_req),
		.reg_rdata        (reg_rdata),
		.reg_hit          (reg_hit),
		.divider_clear    (divider_clear),
		.watchdog_enabled (watchdog_enabled),
		.system_reset_req (system_reset_req)
	);
	task cmp(string n, logic [8:0] e, logic [8:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task acc(logic w, logic r, logic [7:0] a, logic [7:0] d, logic [8:0] e);
		@(negedge clk_sys);
		reg_req = '{w, r, a, d};
		if (r) exp_q.push_back(e);
	endtask : acc
	task conclude;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// Read answers land one cycle after the strobe
	always @(posedge clk_sys) rd_d <= reg_req.rd;
	// Outputs are looked at on the falling edge, away from the edge that launches them
	always @(negedge clk_sys) begin
		if (rd_d) cmp("read", exp_q.pop_front(), {reg_hit, reg_rdata});
		if (system_reset_req === 1'b1) pulses++;
	end
	initial begin
		#1000000;
		fails++;
		conclude();
	end
	initial begin
		logic [1:0] s;
		logic [7:0] a;
		void'($urandom(86508));
		repeat (2) @(negedge clk_sys);
		resetn = 1;
		acc(0, 1, 8'hd3, 0, 9'h100);
		cmp("enable", 1, watchdog_enabled);
		for (int k = 0; k < 16; k++) begin
			s = 2'($urandom % 3);
			acc(1, 0, 8'hd3, {4'(k), s, 2'h3}, 0);
			acc(0, 1, 8'hd3, 0, {1'b1, 4'(k), s, 2'h0});
			cmp("enable", 9'(k != 10), 9'(watchdog_enabled));
			cmp("divclr", 1, divider_clear);
		end
		a = 8'($urandom);
		acc(0, 1, (a == 8'hd3 || a == 8'hfd) ? 8'h00 : a, 0, 0);
		$display("test registers done");
		acc(1, 0, 8'hd3, 8'hab, 0);
		acc(0, 0, 0, 0, 0);
		repeat (703) @(negedge clk_sys);
		// The count register is only ever read, never written
		acc(0, 1, 8'hfd, 0, 9'h105);
		acc(0, 0, 0, 0, 0);
		$display("test count done");
		for (int k = 0; k < 11; k += 10) begin
			acc(1, 0, 8'hd3, {4'(k), 4'hb}, 0);
			acc(0, 0, 0, 0, 0);
			pulses = 0;
			repeat (32832) @(negedge clk_sys);
			cmp("pulses", 9'(k == 0), 9'(pulses));
		end
		$display("test watchdog done");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
